// ===== acc_control.sv
/*
 Digital control of a two-channel analog comparator unit: control
 registers, polarity, change detection, interrupt flags and sleep wake.
 Assumes raw comparator results arrive asynchronously from the analog
 side, and a core that reports entry to sleep and follows resume strobes.
*/
// Notes on behaviour
// - Change during a control read may lose flag
// - Enabled comparator keeps working during sleep
// - Clearing on bit turns only that comparator off
// - Output change wakes sleep when both enables set
// - Instruction after sleep runs first on wake
// - Global enable then enters interrupt service
// - Reset returns all comparator registers to zero
// - Invert bit 4 inverts reported result
// - Result bit 6 follows input compare, polarity
// - Flag set on mismatch edge, first phase sample
// - Control read or write clears the mismatch
module acc_control (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	// APB slave
	input wire acc_pkg::acc_apb_req_s apb_req,
	output acc_pkg::acc_apb_rsp_s apb_rsp,
	// Raw comparator outputs from the analog side
	input wire logic [1:0] comp_raw,
	// Core sleep handshake
	input wire logic sleep_enter,
	output logic core_asleep,
	output logic resume_next,
	output logic isr_request,
	// Interrupt and result pins
	output logic irq,
	output logic [1:0] result_pin,
	output logic [1:0] result_pin_oe
);
	import acc_pkg::*;

	// Control registers, index 0 is the first comparator
	acc_ctrl_s ctrl [2];
	// Auxiliary register of the second comparator
	logic [7:0] two_aux;
	// Sticky flags, enables, interrupt control bits
	logic [1:0] irq_flag;
	logic [1:0] irq_enable;
	logic global_irq_enable;
	logic peripheral_irq_enable;
	// Synchroniser stages for the raw results
	logic [1:0] cmp_s1;
	logic [1:0] cmp_s2;
	// Mismatch latches and previous mismatch
	logic [1:0] phase_latch;
	logic [1:0] read_latch;
	logic [1:0] mm_prev;
	// Phase counter and sequencing state
	logic [1:0] phase;
	acc_state_e state;
	acc_state_e next_state;
	// Registered read data
	logic [31:0] rdata;

	// Combinational helpers
	logic [1:0] comp_result;
	logic [1:0] mismatch;
	logic [1:0] mm_rise;
	logic setup;
	logic access;
	logic wr;
	logic mapped;
	logic ctrl_touch [2];
	logic wake_cond;

	// Read value of a control register with live result, bit 3 zero
	function automatic logic [7:0] ctrl_value(acc_ctrl_s c, logic res);
		acc_ctrl_s v;
		v = c;
		v.result = res;
		v.unused = 1'b0;
		return v;
	endfunction : ctrl_value

	// Address decode against the mapped offsets
	function automatic logic is_mapped(logic [7:0] a);
		return (a == ACC_OFF_COMP_ONE) || (a == ACC_OFF_COMP_TWO)
			|| (a == ACC_OFF_TWO_AUX) || (a == ACC_OFF_FLAG)
			|| (a == ACC_OFF_ENABLE) || (a == ACC_OFF_INTCTL);
	endfunction : is_mapped

	// Bus phases; the slave answers in the first access cycle
	assign setup = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable & ce;
	assign wr = access & apb_req.pwrite;
	assign mapped = is_mapped(apb_req.paddr);
	// A write starts with a read, so any control access clears the mismatch
	assign ctrl_touch[0] = access & (apb_req.paddr == ACC_OFF_COMP_ONE);
	assign ctrl_touch[1] = access & (apb_req.paddr == ACC_OFF_COMP_TWO);

	// Reported result: off reads low, polarity applied
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			comp_result[i] = ctrl[i].on & (cmp_s2[i] ^ ctrl[i].invert);
		end
	end

	// Mismatch is the XOR of the two latches; the flag wants its edge
	assign mismatch = phase_latch ^ read_latch;
	assign mm_rise = mismatch & ~mm_prev;

	// Wake needs a flagged, enabled comparator and the peripheral enable
	assign wake_cond = |(irq_flag & irq_enable) & peripheral_irq_enable;

	// Two-flop synchroniser for the asynchronous analog results
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmp_s1 <= 2'h0;
			cmp_s2 <= 2'h0;
		end else if (ce) begin
			cmp_s1 <= comp_raw;
			cmp_s2 <= cmp_s1;
		end
	end

	// Instruction phase counter, four system clocks per instruction
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase <= ACC_RST_PHASE;
		end else if (ce) begin
			phase <= phase + 2'h1;
		end
	end

	// Control registers; the result bit is never stored
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl[0] <= ACC_RST_CTRL;
			ctrl[1] <= ACC_RST_CTRL;
		end else begin
			for (int i = 0; i < 2; i++) begin
				// Each comparator is written on its own offset only
				if (ctrl_touch[i] && apb_req.pwrite) begin
					ctrl[i] <= ctrl_value(acc_ctrl_s'(apb_req.pwdata[7:0]), 1'b0);
				end
			end
		end
	end

	// Auxiliary register; only its low bits hold state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			two_aux <= ACC_RST_AUX;
		end else if (wr && apb_req.paddr == ACC_OFF_TWO_AUX) begin
			two_aux <= apb_req.pwdata[7:0] & ACC_AUX_WMASK;
		end
	end

	// Enables and interrupt control bits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_enable <= 2'h0;
			global_irq_enable <= 1'b0;
			peripheral_irq_enable <= 1'b0;
		end else if (wr) begin
			if (apb_req.paddr == ACC_OFF_ENABLE) begin
				irq_enable <= apb_req.pwdata[1:0];
			end
			if (apb_req.paddr == ACC_OFF_INTCTL) begin
				global_irq_enable <= apb_req.pwdata[ACC_BIT_GLOBAL];
				peripheral_irq_enable <= apb_req.pwdata[ACC_BIT_PERIPH];
			end
		end
	end

	// Mismatch latches: one samples every first phase, one on access
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase_latch <= 2'h0;
			read_latch <= 2'h0;
			mm_prev <= 2'h0;
		end else if (ce) begin
			// Runs on regardless of sleep, so changes are still seen
			if (phase == ACC_PH_FIRST) begin
				phase_latch <= comp_result;
			end
			for (int i = 0; i < 2; i++) begin
				// A change caught here in the same cycle as the first phase sample is absorbed and never flags
				if (ctrl_touch[i]) begin
					read_latch[i] <= comp_result[i];
				end
			end
			mm_prev <= mismatch;
		end
	end

	// Sticky flags: set on the mismatch edge, write one to clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_flag <= ACC_RST_FLAG;
		end else if (ce) begin
			// Set wins over a clear in the same cycle
			if (wr && apb_req.paddr == ACC_OFF_FLAG) begin
				irq_flag <= (irq_flag & ~apb_req.pwdata[1:0]) | mm_rise;
			end else begin
				irq_flag <= irq_flag | mm_rise;
			end
		end
	end

	// Sleep sequencing: wake, one instruction, then maybe the ISR
	always_comb begin
		next_state = state;
		case (state)
			ACC_RUN: begin
				if (sleep_enter) begin
					next_state = ACC_SLEEP;
				end
			end
			ACC_SLEEP: begin
				if (wake_cond) begin
					next_state = ACC_NEXT;
				end
			end
			ACC_NEXT: begin
				// Following instruction always runs before service
				next_state = global_irq_enable ? ACC_ISR : ACC_RUN;
			end
			ACC_ISR: begin
				next_state = ACC_RUN;
			end
			default: begin
				next_state = ACC_RUN;
			end
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= ACC_RUN;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// Read data is captured in the setup cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0;
		end else if (ce && setup) begin
			case (apb_req.paddr)
				ACC_OFF_COMP_ONE: rdata <= {24'h0, ctrl_value(ctrl[0], comp_result[0])};
				ACC_OFF_COMP_TWO: rdata <= {24'h0, ctrl_value(ctrl[1], comp_result[1])};
				ACC_OFF_TWO_AUX: rdata <= {24'h0, comp_result, two_aux[5:0]};
				ACC_OFF_FLAG: rdata <= {30'h0, irq_flag};
				ACC_OFF_ENABLE: rdata <= {30'h0, irq_enable};
				ACC_OFF_INTCTL: rdata <= {24'h0, global_irq_enable,
					peripheral_irq_enable, 6'h0};
				default: rdata <= 32'h0;
			endcase
		end
	end

	// APB answer in one assignment, so the struct has a single driver
	// Unmapped offsets answer with an error
	assign apb_rsp = '{
		pready: access,
		pslverr: access & ~mapped,
		prdata: rdata
	};

	// Core-facing strobes decoded from the state register
	assign core_asleep = (state == ACC_SLEEP);
	assign resume_next = (state == ACC_NEXT);
	assign isr_request = (state == ACC_ISR);

	// Level interrupt needs flag, enable, peripheral and global enable
	assign irq = wake_cond & global_irq_enable;

	// Result pins drive only while the comparator is on
	// Registered so the pads never see a glitch from the polarity gate
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			result_pin <= 2'h0;
			result_pin_oe <= 2'h0;
		end else if (ce) begin
			result_pin <= comp_result;
			result_pin_oe[0] <= ctrl[0].pin_drive & ctrl[0].on;
			result_pin_oe[1] <= ctrl[1].pin_drive & ctrl[1].on;
		end
	end

	// Read of the first control shows the live polarity result
	chk_result_read: assert property (@(posedge sys_clk) disable iff (rst)
		ce && setup && !apb_req.pwrite && apb_req.paddr == ACC_OFF_COMP_ONE
		|=> apb_rsp.prdata[ACC_BIT_RESULT]
			== ($past(cmp_s2[0] ^ ctrl[0].invert) & $past(ctrl[0].on)))
		else $error("result bit does not follow input and polarity");

	// Inverting swaps the reported value of a running comparator
	chk_invert_swaps: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl[0].on && ctrl[0].invert |-> comp_result[0] == !cmp_s2[0])
		else $error("invert bit does not invert the result");

	// A mismatch edge sets the flag on the next edge
	chk_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
		ce && mm_rise[0] |=> irq_flag[0])
		else $error("mismatch edge did not set the flag");

	// An access reloads the read latch with the live result
	chk_access_clear: assert property (@(posedge sys_clk) disable iff (rst)
		ctrl_touch[1] |=> read_latch[1] == $past(comp_result[1]))
		else $error("control access did not clear the mismatch");

	// Turning one off leaves the other alone
	chk_off_alone: assert property (@(posedge sys_clk) disable iff (rst)
		wr && apb_req.paddr == ACC_OFF_COMP_ONE && !apb_req.pwdata[ACC_BIT_ON]
		|=> !ctrl[0].on && $stable(ctrl[1].on))
		else $error("clearing on bit misbehaved");

	// After reset both comparators are off and the flags clear
	chk_reset_off: assert property (@(posedge sys_clk) disable iff (rst)
		$past(rst) |-> !ctrl[0].on && !ctrl[1].on && two_aux == ACC_RST_AUX
			&& irq_flag == ACC_RST_FLAG)
		else $error("reset did not clear the registers");

	// Phase sampling continues while asleep
	chk_sleep_track: assert property (@(posedge sys_clk) disable iff (rst)
		ce && state == ACC_SLEEP && phase == ACC_PH_FIRST
		|=> phase_latch == $past(comp_result))
		else $error("comparator stopped tracking during sleep");

	// Wake condition in sleep leaves sleep on the next edge
	chk_wake: assert property (@(posedge sys_clk) disable iff (rst)
		ce && core_asleep && wake_cond |=> resume_next)
		else $error("enabled change did not wake the device");

	// Service is entered only straight after the resume step
	chk_next_first: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(isr_request) |-> $past(resume_next))
		else $error("service entered before the following instruction");

	// Global enable at the resume step leads into service
	chk_isr_entry: assert property (@(posedge sys_clk) disable iff (rst)
		ce && resume_next && global_irq_enable |=> isr_request)
		else $error("global enable did not lead into service");

	// Unused bit reads zero in every read of the second control
	chk_unused_zero: assert property (@(posedge sys_clk) disable iff (rst)
		ce && setup && apb_req.paddr == ACC_OFF_COMP_TWO
		|=> apb_rsp.prdata[ACC_BIT_UNUSED] == 1'b0)
		else $error("unused bit does not read zero");

endmodule : acc_control

// ===== acc_pkg.sv
/*
 Package for the comparator control block: register offsets,
 field positions, reset values, phase codes, states and carrier structs.
 Assumes a 32-bit APB with byte addresses and 8-bit registers.
*/
package acc_pkg;

	// Register byte offsets
	localparam logic [7:0] ACC_OFF_COMP_ONE = 8'h00;
	localparam logic [7:0] ACC_OFF_COMP_TWO = 8'h04;
	localparam logic [7:0] ACC_OFF_TWO_AUX = 8'h08;
	localparam logic [7:0] ACC_OFF_FLAG = 8'h0C;
	localparam logic [7:0] ACC_OFF_ENABLE = 8'h10;
	localparam logic [7:0] ACC_OFF_INTCTL = 8'h14;

	// Field positions in the control register
	localparam int ACC_BIT_ON = 7;
	localparam int ACC_BIT_RESULT = 6;
	localparam int ACC_BIT_INVERT = 4;
	localparam int ACC_BIT_UNUSED = 3;

	// Field positions in the interrupt control register
	localparam int ACC_BIT_GLOBAL = 7;
	localparam int ACC_BIT_PERIPH = 6;

	// Writable bits of the auxiliary register
	localparam logic [7:0] ACC_AUX_WMASK = 8'h03;

	// Reset values
	localparam logic [7:0] ACC_RST_CTRL = 8'h00;
	localparam logic [7:0] ACC_RST_AUX = 8'h00;
	localparam logic [1:0] ACC_RST_FLAG = 2'h0;
	localparam logic [1:0] ACC_RST_PHASE = 2'h0;

	// Instruction clock phases, one per system clock
	localparam logic [1:0] ACC_PH_FIRST = 2'h0;
	localparam logic [1:0] ACC_PH_SECOND = 2'h1;

	// Sleep and wake sequencing
	typedef enum logic [1:0] {
		ACC_RUN = 2'b00,
		ACC_SLEEP = 2'b01,
		ACC_NEXT = 2'b10,
		ACC_ISR = 2'b11
	} acc_state_e;

	// Control register layout
	typedef struct packed {
		logic on;
		logic result;
		logic pin_drive;
		logic invert;
		logic unused;
		logic ref_select;
		logic [1:0] channel_select;
	} acc_ctrl_s;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} acc_apb_req_s;

	// APB answer to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} acc_apb_rsp_s;

endpackage : acc_pkg

// ===== acc_control_tb.sv
/*
 Self-checking testbench for the comparator control block: register
 rows, polarity, change flags, sleep wake and reset, all over APB.
 Assumes the APB slave answers with zero wait states when ce is high.
*/
module acc_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import acc_pkg::*;

	logic sys_clk;
	logic rst;
	logic ce; // Kept high except once, where the stall path is exercised
	acc_apb_req_s req;
	acc_apb_rsp_s rsp;
	logic [1:0] comp_raw;
	logic sleep_enter;
	logic core_asleep;
	logic resume_next;
	logic isr_request;
	logic irq;
	logic [1:0] result_pin;
	logic [1:0] result_pin_oe;
	int mismatches;
	int check_count;
	logic [31:0] rdat;
	logic rerr; // Error response taken at the access edge
	// Rows: address, write data, raw inputs, expected read back
	logic [31:0] rows [5] = '{32'h00FF00F7, 32'h00EF00A7, 32'h00EF01E7,
		32'h007F0137, 32'h04FF02B7};
	logic [7:0] offs [6] = '{ACC_OFF_COMP_ONE, ACC_OFF_COMP_TWO, ACC_OFF_TWO_AUX,
		ACC_OFF_FLAG, ACC_OFF_ENABLE, ACC_OFF_INTCTL};

	acc_control dut (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.apb_req(req),
		.apb_rsp(rsp),
		.comp_raw(comp_raw),
		.sleep_enter(sleep_enter),
		.core_asleep(core_asleep),
		.resume_next(resume_next),
		.isr_request(isr_request),
		.irq(irq),
		.result_pin(result_pin),
		.result_pin_oe(result_pin_oe)
	);

	// Free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Compare and count; four-state equality so unknowns never match
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= {24'h000000, d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(32'h0, 32'h1); // Slave never answered
		end
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr

	// Let a raw change pass the synchroniser and a full phase round
	task automatic settle(input logic [1:0] raw);
		@(posedge sys_clk);
		comp_raw <= raw;
		repeat (10) @(posedge sys_clk);
	endtask : settle

	// Every register reads its reset value of zero
	task automatic reset_reads();
		foreach (offs[i]) begin
			apb(1'b0, offs[i], 8'h00);
			chk(rdat, 32'h0);
		end
		chk(irq, 1'b0);
	endtask : reset_reads

	// Sleep, flip the raw input, expect the wake pulse then maybe service
	task automatic nap(input logic [1:0] raw, input logic isr_exp);
		int n;
		@(posedge sys_clk);
		sleep_enter <= 1'b1;
		@(posedge sys_clk);
		sleep_enter <= 1'b0;
		@(negedge sys_clk);
		chk(core_asleep, 1'b1);
		@(posedge sys_clk);
		comp_raw <= raw;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (resume_next !== 1'b1 && n < 40);
		chk(resume_next, 1'b1);
		@(negedge sys_clk);
		chk(isr_request, isr_exp);
		apb(1'b0, ACC_OFF_COMP_ONE, 8'h00);
		wr(ACC_OFF_FLAG, 8'h03);
	endtask : nap

	// Closing verdict, reached from the main flow or the watchdog
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	// Watchdog sized well above the few hundred cycles the flow needs
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		end_of_test();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		req = '0;
		comp_raw = 2'b00;
		sleep_enter = 1'b0;
		mismatches = 0;
		check_count = 0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		reset_reads();
		// Row loop: polarity, result bit, unused bit, enable, pin drive
		foreach (rows[i]) begin
			settle(rows[i][9:8]);
			wr(rows[i][31:24], rows[i][23:16]);
			repeat (4) @(posedge sys_clk);
			apb(1'b0, rows[i][31:24], 8'h00);
			chk(rdat, {24'h0, rows[i][7:0]});
			chk({result_pin_oe[rows[i][26]], result_pin[rows[i][26]]},
				{rows[i][7] & rows[i][5], rows[i][6]});
		end
		// The second comparator leaves the first one alone
		apb(1'b0, ACC_OFF_COMP_ONE, 8'h00);
		chk(rdat, 32'h37);
		// Unmapped address: error response, zero data
		apb(1'b0, 8'h20, 8'h00);
		chk(rerr, 1'b1);
		chk(rdat, 32'h0);
		// First enable: let the bias settle, clear mismatch and flags
		wr(ACC_OFF_COMP_ONE, 8'h80);
		repeat (100) @(posedge sys_clk);
		settle(2'b00);
		apb(1'b0, ACC_OFF_COMP_ONE, 8'h00);
		wr(ACC_OFF_FLAG, 8'h03);
		wr(ACC_OFF_ENABLE, 8'h01);
		wr(ACC_OFF_INTCTL, 8'hC0);
		@(negedge sys_clk);
		chk(irq, 1'b0);
		settle(2'b01);
		chk(irq, 1'b1);
		apb(1'b0, ACC_OFF_FLAG, 8'h00);
		chk(rdat, 32'h1);
		wr(ACC_OFF_FLAG, 8'h01);
		// The clear lands at the access edge; look once it has settled
		@(negedge sys_clk);
		chk(irq, 1'b0);
		// Read clears mismatch, so the return sets the flag; masked
		apb(1'b0, ACC_OFF_COMP_ONE, 8'h00);
		wr(ACC_OFF_ENABLE, 8'h00);
		settle(2'b00);
		apb(1'b0, ACC_OFF_FLAG, 8'h00);
		chk(rdat, 32'h1);
		chk(irq, 1'b0);
		// No read in between: the return only ends the mismatch
		wr(ACC_OFF_FLAG, 8'h03);
		settle(2'b01);
		apb(1'b0, ACC_OFF_FLAG, 8'h00);
		chk(rdat, 32'h0);
		settle(2'b00);
		// Sleep wake, with and without the global enable
		apb(1'b0, ACC_OFF_COMP_ONE, 8'h00);
		wr(ACC_OFF_FLAG, 8'h03);
		wr(ACC_OFF_ENABLE, 8'h01);
		nap(2'b01, 1'b1);
		wr(ACC_OFF_INTCTL, 8'h40);
		nap(2'b00, 1'b0);
		// Clock enable low freezes change detection; it catches up after
		wr(ACC_OFF_INTCTL, 8'hC0);
		ce <= 1'b0;
		settle(2'b01);
		chk(irq, 1'b0);
		ce <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk(irq, 1'b1);
		// Mid-run reset returns everything to zero, pending flag too
		wr(ACC_OFF_COMP_ONE, 8'hFF);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		reset_reads();
		end_of_test();
	end
endmodule : acc_control_tb
